//--- rtl/pmc_power_mode.sv
// power mode control: idle, stop, wake-up timer, power-fail supervision, reset sequencing.
// assumes i_rst_n is the power-on reset, comparators and the slow tick are synchronous to i_mclk,
// and the register write strobe marks completion of the writing instruction.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - writing 1 to the idle bit halts instruction fetch after that write
// - idle keeps peripheral clocks and the power monitor running
// - any enabled interrupt ends idle and resumes processing
// - leaving idle clears the idle bit by hardware; execution continues
// - stop halts the processor while keeping its state and memories
// - stop ends on I/O interrupt, power-fail warning or power-fail reset
// - a slow-oscillator wake-up timer can end stop mode
// - wake interval is programmable in single slow-oscillator steps, up to about 8 s
// - power monitor is always on when running; may be off only in stop; the code also drops it between polls in power-fail reset
// - the stop-mode monitor disable bit resets to 1
// - monitor off in stop: no warning, no power-fail reset detected
// - power-on reset always resets, whatever the disable bit says
// - monitor is turned back on before stop exit completes
// - supply below warning threshold at stop exit sets the warning flag
// - supply below reset threshold at stop exit puts the processor in reset
// - after power-on, wait about 25 us for the oscillator before running
// - all port pins are high impedance during any reset
// - after power-fail reset monitor is continuous or every 2^11..2^13 ticks
// - check two ticks, confirm one more, then warm up and start at 8000h
// - pin or watchdog reset keeps power on and exits within 20 cycles
module pmc_power_mode #(
   parameter int WARMUP_CYC = pmc_pkg::OSC_SETTLE_CYC,
   parameter int WAKE_W     = pmc_pkg::WAKE_W
) (
   input  wire logic                     i_mclk,
   input  wire logic                     i_rst_n,
   input  wire pmc_pkg::pmc_bus_req_type i_bus,
   output logic [pmc_pkg::DATA_W-1:0]    o_rd_data,
   input  wire logic                     i_slow_tick,
   input  wire logic                     i_irq_pending,
   input  wire logic                     i_io_irq,
   input  wire logic                     i_below_warn,
   input  wire logic                     i_below_reset,
   input  wire logic                     i_ext_reset,
   output logic                          o_cpu_halt,
   output logic                          o_cpu_reset,
   output logic                          o_stop_mode,
   output logic                          o_periph_clk_en,
   output logic                          o_osc_en,
   output logic                          o_monitor_en,
   output logic                          o_pins_hiz,
   output logic                          o_warn_flag,
   output logic [15:0]                   o_reset_vector
);
   import pmc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   pmc_state_type     state_r;
   pmc_state_type     state_nxt;
   logic              off_in_stop_r;
   logic [1:0]        pf_mode_r;
   logic [WAKE_W-1:0] wake_interval_r;
   logic              warn_flag_r;
   logic [12:0]       cnt_r;
   logic              wake_match;
   logic              poll_mon_on;
   logic              poll_recovered;
   logic              stop_mon_on;
   logic              wr_ckc;
   logic              wr_pwc;

   function automatic logic hit(input pmc_bus_req_type b, input logic [ADDR_W-1:0] ofs);
      hit = b.addr == ofs;
   endfunction : hit

   assign wr_ckc      = i_bus.wr && hit(i_bus, OFS_CLOCK_CONTROL);
   assign wr_pwc      = i_bus.wr && hit(i_bus, OFS_POWER_CONTROL);
   // monitor may be dropped only while stopped or polling in power-fail reset; disabled means its comparators are ignored
   assign stop_mon_on = !off_in_stop_r;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   pmc_wake_timer #(
      .W (WAKE_W)
   ) u_wake (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_run      (state_r == ST_STOP),
      .i_tick     (i_slow_tick),
      .i_interval (wake_interval_r),
      .o_match    (wake_match)
   );

   pmc_pf_poller u_poll (
      .i_mclk        (i_mclk),
      .i_rst_n       (i_rst_n),
      .i_active      (state_r == ST_PFRESET),
      .i_tick        (i_slow_tick),
      .i_mode        (pf_mode_r),
      .i_below_reset (i_below_reset),
      .o_monitor_on  (poll_mon_on),
      .o_recovered   (poll_recovered)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_WARMUP: begin
            if (cnt_r == 13'(WARMUP_CYC - 1)) state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (i_below_reset) begin
               state_nxt = ST_PFRESET;
            end else if (wr_ckc && i_bus.wdata[CKC_STOP_BIT]) begin
               state_nxt = ST_STOP;
            end else if (wr_ckc && i_bus.wdata[CKC_IDLE_BIT]) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (i_below_reset) begin
               state_nxt = ST_PFRESET;
            end else if (i_irq_pending) begin
               state_nxt = ST_RUN;
            end
         end
         ST_STOP: begin
            if (stop_mon_on && i_below_reset) begin
               state_nxt = ST_PFRESET;
            end else if (i_io_irq || wake_match || (stop_mon_on && i_below_warn)) begin
               state_nxt = ST_STOPEXIT;
            end
         end
         ST_STOPEXIT: begin
            // monitor is back on here; one more look decides reset or resume
            if (i_below_reset) state_nxt = ST_PFRESET;
            else state_nxt = ST_RUN;
         end
         ST_PFRESET: begin
            if (poll_recovered) state_nxt = ST_WARMUP;
         end
         ST_EXTRESET: begin
            if (!i_ext_reset && cnt_r == 13'(EXT_EXIT_CYC - 1)) state_nxt = ST_RUN;
         end
         default: state_nxt = ST_WARMUP;
      endcase
      // pin or watchdog reset overrides everything but power-fail reset and warm-up
      if (i_ext_reset && state_r != ST_PFRESET && state_r != ST_WARMUP) state_nxt = ST_EXTRESET;
   end

   // power-on reset always lands in warm-up, regardless of the disable bit
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) state_r <= ST_WARMUP;
      else state_r <= state_nxt;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || state_nxt != state_r) begin
         cnt_r <= '0;
      end else if (state_r == ST_WARMUP || (state_r == ST_EXTRESET && !i_ext_reset)) begin
         cnt_r <= cnt_r + 13'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         off_in_stop_r <= OFF_IN_STOP_RST;
         pf_mode_r     <= PF_MODE_RST;
      end else if (wr_pwc) begin
         off_in_stop_r <= i_bus.wdata[PWC_OFF_IN_STOP_BIT];
         pf_mode_r     <= i_bus.wdata[PWC_PF_MODE_LSB +: 2];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) wake_interval_r <= WAKE_W'(WAKE_INTERVAL_RST);
      else if (i_bus.wr && hit(i_bus, OFS_WAKE_INTERVAL)) wake_interval_r <= i_bus.wdata[WAKE_W-1:0];
   end

   // warning flag: hardware set wins over a software write-one-to-clear in the same cycle
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         warn_flag_r <= 1'b0;
      end else if ((state_r == ST_STOPEXIT && i_below_warn && !i_below_reset) ||
                   ((state_r == ST_RUN || state_r == ST_IDLE) && i_below_warn)) begin
         warn_flag_r <= 1'b1;
      end else if (wr_pwc && i_bus.wdata[PWC_WARN_FLAG_BIT]) begin
         warn_flag_r <= 1'b0;
      end
   end

   // idle bit reads from the state, so it clears itself on leaving idle
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_rd_data <= '0;
      end else if (i_bus.rd) begin
         unique case (1'b1)
            hit(i_bus, OFS_CLOCK_CONTROL):
               o_rd_data <= DATA_W'({state_r == ST_STOP, state_r == ST_IDLE});
            hit(i_bus, OFS_POWER_CONTROL):
               o_rd_data <= DATA_W'({warn_flag_r, pf_mode_r, off_in_stop_r});
            hit(i_bus, OFS_WAKE_INTERVAL):
               o_rd_data <= DATA_W'(wake_interval_r);
            hit(i_bus, OFS_STATUS):
               o_rd_data <= DATA_W'(state_r) << STS_STATE_LSB;
            default:
               o_rd_data <= '0;
         endcase
      end else begin
         o_rd_data <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all registered; mode outputs from the next state, warning flag from its register
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_cpu_halt      <= 1'b1;
         o_cpu_reset     <= 1'b1;
         o_stop_mode     <= 1'b0;
         o_periph_clk_en <= 1'b0;
         o_osc_en        <= 1'b1;
         o_monitor_en    <= 1'b1;
         o_pins_hiz      <= 1'b1;
         o_warn_flag     <= 1'b0;
         o_reset_vector  <= RESET_VECTOR;
      end else begin
         o_cpu_halt      <= state_nxt != ST_RUN;
         o_cpu_reset     <= state_nxt inside {ST_WARMUP, ST_PFRESET, ST_EXTRESET};
         o_stop_mode     <= state_nxt == ST_STOP;
         o_periph_clk_en <= state_nxt inside {ST_RUN, ST_IDLE};
         // oscillator and regulator drop in stop and in power-fail reset only
         o_osc_en        <= !(state_nxt inside {ST_STOP, ST_PFRESET});
         o_monitor_en    <= (state_nxt == ST_STOP) ? stop_mon_on :
                            (state_nxt == ST_PFRESET) ? poll_mon_on : 1'b1;
         o_pins_hiz      <= state_nxt inside {ST_WARMUP, ST_PFRESET, ST_EXTRESET};
         o_warn_flag     <= warn_flag_r;
         o_reset_vector  <= RESET_VECTOR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   idle_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r == ST_RUN && wr_ckc && i_bus.wdata[CKC_IDLE_BIT] && !i_bus.wdata[CKC_STOP_BIT]
       && !i_below_reset && !i_ext_reset) |=> o_cpu_halt)
      else $error("idle write did not halt the processor");

   idle_wake_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r == ST_IDLE && i_irq_pending && !i_below_reset && !i_ext_reset) |=> !o_cpu_halt)
      else $error("interrupt did not end idle");

   idle_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r != ST_IDLE && i_bus.rd && hit(i_bus, OFS_CLOCK_CONTROL)) |=> !o_rd_data[CKC_IDLE_BIT])
      else $error("idle bit still set outside idle");

   stop_halt_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_stop_mode |-> o_cpu_halt && !o_cpu_reset)
      else $error("processor not halted in stop");

   wake_exit_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r == ST_STOP && wake_match && !i_ext_reset && !(stop_mon_on && i_below_reset))
      |=> state_r == ST_STOPEXIT)
      else $error("wake-up match did not leave stop");

   mon_on_run_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (!o_stop_mode && !o_cpu_reset) |-> o_monitor_en)
      else $error("monitor off outside stop");

   mon_off_stop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r == ST_STOP && off_in_stop_r && i_below_reset && !i_io_irq && !wake_match
       && !i_ext_reset) |=> state_r == ST_STOP)
      else $error("disabled monitor caused a reset in stop");

   exit_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r == ST_STOPEXIT && i_below_reset) |=> ##1 o_cpu_reset)
      else $error("low supply at stop exit did not reset");

   warmup_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r == ST_WARMUP && cnt_r != 13'(WARMUP_CYC - 1)) |=> state_r == ST_WARMUP)
      else $error("warm-up ended early");

   pins_hiz_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      o_cpu_reset |-> o_pins_hiz)
      else $error("pins driven during reset");

   ext_exit_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      (state_r == ST_EXTRESET && $fell(i_ext_reset)) |-> ##[1:19] !o_cpu_reset)
      else $error("pin reset exit too slow");

endmodule : pmc_power_mode

//--- rtl/pmc_pkg.sv
// power mode control: shared constants, register layout, state codes and carrier types.
// assumes one 250 MHz clock and a slow ring-oscillator tick already synchronous to it.
package pmc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   localparam logic [ADDR_W-1:0] OFS_CLOCK_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_POWER_CONTROL = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_WAKE_INTERVAL = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_STATUS        = 4'h3;

   // clock_control_reg fields
   localparam int CKC_IDLE_BIT = 0;
   localparam int CKC_STOP_BIT = 1;
   // power_control_reg fields
   localparam int PWC_OFF_IN_STOP_BIT = 0;
   localparam int PWC_PF_MODE_LSB     = 1;
   localparam int PWC_WARN_FLAG_BIT   = 3;
   // status fields
   localparam int STS_STATE_LSB       = 0;

   localparam logic       OFF_IN_STOP_RST   = 1'b1;
   localparam logic [1:0] PF_MODE_RST       = 2'h0;
   localparam logic [15:0] WAKE_INTERVAL_RST = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int OSC_SETTLE_US    = 25;
   localparam int OSC_SETTLE_CYC   = (OSC_SETTLE_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int EXT_EXIT_MAX_CYC = 20;
   localparam int EXT_EXIT_CYC     = 4;
   localparam int PF_CHECK_TICKS   = 2;
   localparam int PF_SPACING_BASE  = 10;
   localparam int WAKE_W           = 16;
   localparam logic [15:0] RESET_VECTOR = 16'h8000;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } pmc_bus_req_type;

   typedef enum logic [6:0] {
      ST_WARMUP   = 7'b000_0001,
      ST_RUN      = 7'b000_0010,
      ST_IDLE     = 7'b000_0100,
      ST_STOP     = 7'b000_1000,
      ST_STOPEXIT = 7'b001_0000,
      ST_PFRESET  = 7'b010_0000,
      ST_EXTRESET = 7'b100_0000
   } pmc_state_type;

   typedef enum logic [2:0] {
      PH_WAIT    = 3'b001,
      PH_CHECK   = 3'b010,
      PH_CONFIRM = 3'b100
   } pmc_phase_type;

endpackage : pmc_pkg

//--- rtl/pmc_wake_timer.sv
// wake-up timer counting slow-oscillator ticks while stopped.
// assumes i_tick is a one-cycle pulse per slow-oscillator period.
`timescale 1ns/1ps
module pmc_wake_timer #(
   parameter int W = pmc_pkg::WAKE_W
) (
   input  wire logic         i_mclk,
   input  wire logic         i_rst_n,
   input  wire logic         i_run,
   input  wire logic         i_tick,
   input  wire logic [W-1:0] i_interval,
   output logic              o_match
);
   import pmc_pkg::*;

   logic [W-1:0] cnt_r;

   // interval of zero disables the timer; one step is one tick
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || !i_run) begin
         cnt_r   <= '0;
         o_match <= 1'b0;
      end else if (i_tick && i_interval != '0) begin
         if (cnt_r + W'(1) == i_interval) begin
            cnt_r   <= '0;
            o_match <= 1'b1;
         end else begin
            cnt_r   <= cnt_r + W'(1);
            o_match <= 1'b0;
         end
      end else begin
         o_match <= 1'b0;
      end
   end

endmodule : pmc_wake_timer

//--- rtl/pmc_pf_poller.sv
// power-fail recovery poller used while held in power-fail reset.
// assumes i_below_reset is the reset-threshold comparator, valid only while o_monitor_on.
`timescale 1ns/1ps
module pmc_pf_poller (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_active,
   input  wire logic       i_tick,
   input  wire logic [1:0] i_mode,
   input  wire logic       i_below_reset,
   output logic            o_monitor_on,
   output logic            o_recovered
);
   import pmc_pkg::*;

   pmc_phase_type phase_r;
   logic [13:0]   cnt_r;
   logic [13:0]   spacing;

   // mode 0 is continuous; 1..3 give 2^11..2^13 ticks between checks
   assign spacing = (i_mode == 2'h0) ? 14'h0001 : 14'(1 << (PF_SPACING_BASE + 32'(i_mode)));

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n || !i_active) begin
         phase_r     <= PH_WAIT;
         cnt_r       <= '0;
         o_recovered <= 1'b0;
      end else begin
         o_recovered <= 1'b0;
         unique case (phase_r)
            PH_WAIT: begin
               if (i_mode == 2'h0 || (i_tick && cnt_r == spacing - 14'h0001)) begin
                  phase_r <= PH_CHECK;
                  cnt_r   <= '0;
               end else if (i_tick) begin
                  cnt_r <= cnt_r + 14'h0001;
               end
            end
            PH_CHECK: begin
               if (i_below_reset) begin
                  phase_r <= PH_WAIT;
                  cnt_r   <= '0;
               end else if (i_tick) begin
                  if (cnt_r == 14'(PF_CHECK_TICKS - 1)) begin
                     phase_r <= PH_CONFIRM;
                     cnt_r   <= '0;
                  end else begin
                     cnt_r <= cnt_r + 14'h0001;
                  end
               end
            end
            PH_CONFIRM: begin
               if (i_below_reset) begin
                  phase_r <= PH_WAIT;
               end else if (i_tick) begin
                  o_recovered <= 1'b1;
                  phase_r     <= PH_WAIT;
               end
            end
         endcase
      end
   end

   assign o_monitor_on = (phase_r != PH_WAIT);

endmodule : pmc_pf_poller

//--- testbench/tb.sv
// self-checking bench for the power mode control block.
// assumes the block alone, driven at rising edges, with a shortened oscillator warm-up.
`timescale 1ns/1ps
module tb;
   import pmc_pkg::*;

   localparam int WARM      = 8;
   localparam int MAX_TICKS = 20000;

   logic                i_mclk;
   logic                i_rst_n;
   pmc_bus_req_type     bus;
   logic [DATA_W-1:0]   rd_data;
   logic                slow_tick;
   logic                irq_pending;
   logic                io_irq;
   logic                below_warn;
   logic                below_reset;
   logic                ext_reset;
   logic                cpu_halt;
   logic                cpu_reset;
   logic                stop_mode;
   logic                periph_clk_en;
   logic                osc_en;
   logic                monitor_en;
   logic                pins_hiz;
   logic                warn_flag;
   logic [15:0]         reset_vector;
   int                  error_cnt;
   int                  check_count;
   int                  cycles;
   int                  n;
   wire logic [2:0]     watch = {cpu_reset, stop_mode, cpu_halt};

   // write flag, address, data, expected read-back
   typedef struct {logic w; logic [3:0] a; logic [15:0] d; logic [15:0] e;} pmc_row_type;
   pmc_row_type rows[9] = '{
      '{1'b0, 4'h1, 16'h0000, 16'h0001},
      '{1'b0, 4'h2, 16'h0000, 16'h0000},
      '{1'b0, 4'h3, 16'h0000, 16'h0002},
      '{1'b0, 4'h0, 16'h0000, 16'h0000},
      '{1'b1, 4'h2, 16'hFFFF, 16'hFFFF},
      '{1'b1, 4'h4, 16'h5555, 16'h0000},
      '{1'b1, 4'hF, 16'hAAAA, 16'h0000},
      '{1'b1, 4'h1, 16'h0006, 16'h0006},
      '{1'b1, 4'h1, 16'h0001, 16'h0001}};

   pmc_power_mode #(.WARMUP_CYC(WARM), .WAKE_W(WAKE_W)) DUT (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rd_data(rd_data),
      .i_slow_tick(slow_tick), .i_irq_pending(irq_pending), .i_io_irq(io_irq),
      .i_below_warn(below_warn), .i_below_reset(below_reset), .i_ext_reset(ext_reset),
      .o_cpu_halt(cpu_halt), .o_cpu_reset(cpu_reset), .o_stop_mode(stop_mode),
      .o_periph_clk_en(periph_clk_en), .o_osc_en(osc_en), .o_monitor_en(monitor_en),
      .o_pins_hiz(pins_hiz), .o_warn_flag(warn_flag), .o_reset_vector(reset_vector));

   initial i_mclk = 1'b0;
   always #2 i_mclk = ~i_mclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // a hang is cut short here rather than left to the simulator
   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == MAX_TICKS) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_mclk);
      bus.wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe is taken
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_mclk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_mclk);
      bus.rd <= 1'b0;
      #1 chk_word(rd_data, e);
   endtask : rd

   task automatic settle(input int k);
      repeat (k) @(posedge i_mclk);
      #1;
   endtask : settle

   // bounded wait on halt (0), stop (1) or cpu reset (2)
   task automatic wait_bit(input int idx, input logic lvl, input int lim);
      int k;
      k = 0;
      while (watch[idx] !== lvl && k < lim) begin
         settle(1);
         k++;
      end
      chk_bit(watch[idx], lvl);
   endtask : wait_bit

   task automatic tick;
      @(posedge i_mclk);
      slow_tick <= 1'b1;
      @(posedge i_mclk);
      slow_tick <= 1'b0;
      repeat (3) @(posedge i_mclk);
      #1;
   endtask : tick

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {error_cnt, check_count, cycles} = '0;
      i_rst_n = 1'b0;
      bus = '0;
      {slow_tick, irq_pending, io_irq, below_warn, below_reset, ext_reset} = '0;
      settle(3);
      chk_bit(pins_hiz, 1'b1);
      @(posedge i_mclk);
      i_rst_n <= 1'b1;
      settle(WARM - 1);
      chk_bit(cpu_reset, 1'b1);
      wait_bit(2, 1'b0, 6);
      chk_bit(monitor_en, 1'b1);
      chk_word(reset_vector, 16'h8000);
      foreach (rows[i]) begin
         if (rows[i].w)
            wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      // idle entry and interrupt exit
      wr(OFS_CLOCK_CONTROL, 16'h0001);
      settle(2);
      chk_bit(cpu_halt, 1'b1);
      chk_bit(periph_clk_en, 1'b1);
      chk_bit(monitor_en, 1'b1);
      rd(OFS_CLOCK_CONTROL, 16'h0001);
      @(posedge i_mclk);
      irq_pending <= 1'b1;
      wait_bit(0, 1'b0, 5);
      @(posedge i_mclk);
      irq_pending <= 1'b0;
      rd(OFS_CLOCK_CONTROL, 16'h0000);
      // stop with the monitor off, ended by the wake-up timer
      wr(OFS_WAKE_INTERVAL, 16'h0003);
      wr(OFS_CLOCK_CONTROL, 16'h0002);
      settle(2);
      chk_bit(stop_mode, 1'b1);
      chk_bit(periph_clk_en, 1'b0);
      chk_bit(monitor_en, 1'b0);
      @(posedge i_mclk);
      below_reset <= 1'b1;
      settle(6);
      chk_bit(cpu_reset, 1'b0);
      @(posedge i_mclk);
      below_reset <= 1'b0;
      tick();
      tick();
      chk_bit(stop_mode, 1'b1);
      tick();
      wait_bit(1, 1'b0, 4);
      chk_bit(monitor_en, 1'b1);
      chk_bit(cpu_halt, 1'b0);
      // stop with the monitor on, ended by a warning; a set beats a clear in the same cycle
      wr(OFS_WAKE_INTERVAL, 16'h0000);
      wr(OFS_POWER_CONTROL, 16'h0000);
      wr(OFS_CLOCK_CONTROL, 16'h0002);
      settle(2);
      chk_bit(monitor_en, 1'b1);
      @(posedge i_mclk);
      below_warn <= 1'b1;
      wait_bit(1, 1'b0, 8);
      settle(2);
      chk_bit(warn_flag, 1'b1);
      wr(OFS_POWER_CONTROL, 16'h0008);
      rd(OFS_POWER_CONTROL, 16'h0008);
      @(posedge i_mclk);
      below_warn <= 1'b0;
      wr(OFS_POWER_CONTROL, 16'h0008);
      rd(OFS_POWER_CONTROL, 16'h0000);
      // a reset-level supply during stop becomes a power-fail reset; continuous recovery
      wr(OFS_CLOCK_CONTROL, 16'h0002);
      settle(2);
      @(posedge i_mclk);
      below_reset <= 1'b1;
      wait_bit(2, 1'b1, 8);
      chk_bit(pins_hiz, 1'b1);
      chk_bit(osc_en, 1'b0);
      @(posedge i_mclk);
      below_reset <= 1'b0;
      for (n = 0; n < 8 && cpu_reset !== 1'b0; n++)
         tick();
      chk_bit(cpu_reset, 1'b0);
      // monitor off in stop, left by an I/O interrupt into a reset-level supply
      wr(OFS_POWER_CONTROL, 16'h0001);
      wr(OFS_CLOCK_CONTROL, 16'h0002);
      below_reset <= 1'b1;
      settle(3);
      chk_bit(stop_mode, 1'b1);
      @(posedge i_mclk);
      io_irq <= 1'b1;
      @(posedge i_mclk);
      io_irq <= 1'b0;
      wait_bit(2, 1'b1, 4);
      chk_bit(stop_mode, 1'b0);
      @(posedge i_mclk);
      below_reset <= 1'b0;
      for (n = 0; n < 8 && cpu_reset !== 1'b0; n++)
         tick();
      chk_bit(cpu_reset, 1'b0);
      // periodic polling every 2^11 ticks: 2048 waiting, two checking, one confirming
      wr(OFS_POWER_CONTROL, 16'h0002);
      below_reset <= 1'b1;
      wait_bit(2, 1'b1, 8);
      chk_bit(monitor_en, 1'b0);
      @(posedge i_mclk);
      below_reset <= 1'b0;
      repeat (2050) tick();
      chk_bit(cpu_reset, 1'b1);
      chk_bit(monitor_en, 1'b1);
      for (n = 0; n < 4 && cpu_reset !== 1'b0; n++)
         tick();
      chk_bit(cpu_reset, 1'b0);
      // pin or watchdog reset keeps power up and leaves quickly
      @(posedge i_mclk);
      ext_reset <= 1'b1;
      wait_bit(2, 1'b1, 8);
      chk_bit(osc_en, 1'b1);
      chk_bit(monitor_en, 1'b1);
      chk_bit(pins_hiz, 1'b1);
      @(posedge i_mclk);
      ext_reset <= 1'b0;
      wait_bit(2, 1'b0, 20);
      // power-on reset in mid-stop lands in warm-up and restores the disable bit
      wr(OFS_POWER_CONTROL, 16'h0000);
      wr(OFS_CLOCK_CONTROL, 16'h0002);
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      @(posedge i_mclk);
      i_rst_n <= 1'b1;
      settle(1);
      chk_bit(cpu_reset, 1'b1);
      chk_bit(stop_mode, 1'b0);
      rd(OFS_POWER_CONTROL, 16'h0001);
      end_of_test();
   end
endmodule : tb
